// >>> rtl/sdcd_core.sv
// simd dsp core datapath: two elements, banks, generators, cache, exchange, timer
//
// Functional notes
// - first element always runs; second only while its enable bit is set.
// - each instruction goes to both elements at once, own operands each.
// - in simd each generator-driven load into the data registers moves two values, one per element.
// - alu, multiplier, shifter finish in one cycle; alu and multiply run together.
// - fixed 32-bit, float 32-bit and extended float 40-bit formats.
// - core timer raises periodic interrupts, may drive the flag pin.
// - each element holds thirty-two 40-bit registers, sixteen per bank.
// - primary banks after reset; secondary only by mode word bits.
// - four bit registers with set, clear, toggle, test and xor.
// - exchange register links both 64-bit buses and 40-bit registers.
// - data bus carries data only; program bus carries instructions and data.
// - one cycle fetches four operands plus one instruction from cache.
// - cache keeps only fetches that collided with program bus data access.
// - generators hold thirty-two buffer sets, sixteen per bank.
// - generator pointers wrap at buffer bounds anywhere in memory.
// - one 48-bit word does multiply and add conditionally, its memory fetches always.
// - 16-bit and 32-bit compact instructions are accepted too.
// - compact instructions from the async memory region are refused.
`timescale 1ns/1ps
module sdcd_core import sdcd_pkg::*; #(
  parameter int AW = 32, // address width
  parameter int CN = 8, // instruction cache entries
  parameter logic [AW-1:0] ASYNC_BASE = {1'b1, {(AW-1){1'b0}}} // async region start
) (
  input wire logic mclk_in, // core clock
  input wire logic resetn_in, // sync reset, active low
  input wire logic [3:0] mode_control_word_one_in, // mode bits
  input wire logic [4:0] dbg_sel_in, // register observed
  input wire logic [63:0] prog_rdata_in, // program bus read data
  input wire logic [63:0] data_rdata_in, // data bus read data
  output logic [AW-1:0] prog_addr_out, // program bus address
  output logic prog_rd_out, // program bus read
  output logic prog_wr_out, // program bus write
  output logic [63:0] prog_wdata_out, // program bus write data
  output logic [AW-1:0] data_addr_out, // data bus address
  output logic data_rd_out, // data bus read
  output logic data_wr_out, // data bus write
  output logic [63:0] data_wdata_out, // data bus write data
  output logic timer_irq_out, // timer expiry pulse
  output logic timer_expired_flag_pin_out, // flag pin level
  output logic timer_expired_flag_pin_oe_out, // flag pin driven
  output logic bit_test_out, // last bit test result
  output logic fetch_fault_out, // sticky refused fetch
  output logic second_pe_active_out, // second element on
  output logic [39:0] dbg_x_out, // first element register
  output logic [39:0] dbg_y_out // second element register
);
  localparam int CIW = $clog2(CN);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0][39:0] xr; // first element data registers
    logic [31:0][39:0] yr;
    logic [1:0][1:0][63:0] mr; // result registers [bank][element]
    logic [1:0][15:0][AW-1:0] ai; // generator pointers
    logic [1:0][15:0][AW-1:0] am; // modifiers
    logic [1:0][15:0][AW-1:0] ab; // bases
    logic [1:0][15:0][AW-1:0] al; // lengths
    logic [3:0][31:0] ubr; // bit registers
    logic [63:0] bxr; // bus exchange register
    logic [31:0] tper;
    logic [31:0] tcnt;
    logic [1:0] tctl;
    logic [3:0] mode;
    logic [1:0] az;
    logic [1:0] an;
    logic [AW-1:0] pc;
    logic [AW-1:0] faddr;
    logic fpend;
    logic cpend;
    logic miss;
    logic [47:0] cword;
    logic [CN-1:0] cv;
    logic [CN-1:0][AW-1:0] ctag;
    logic [CN-1:0][47:0] cdat;
    logic ldd;
    logic ldp;
    logic ldd_x;
    logic ldp_x;
    logic [4:0] ldd_r;
    logic [4:0] ldp_r;
    logic [AW-1:0] pa;
    logic [AW-1:0] da;
    logic prd;
    logic pwr;
    logic drd;
    logic dwr;
    logic [63:0] pwd;
    logic [63:0] dwd;
    logic tirq;
    logic tflag;
    logic utest;
    logic fault;
    logic [39:0] dbx;
    logic [39:0] dby;
  } sdcd_state_type;

  sdcd_state_type r;
  sdcd_state_type next_r;

  // ****************************************
  // decode
  // ****************************************
  logic ins_v;
  logic [47:0] ins;
  logic [AW-1:0] len16;
  logic compact;
  logic flt;
  logic exe;
  logic pbusy;
  logic [AW-1:0] nt;
  logic [CIW-1:0] ti;
  logic [CIW-1:0] fi;
  logic rb;
  logic [1:0] ena;
  logic [1:0] ok;
  logic [3:0] ags [2];
  logic [AW-1:0] agn [2];
  logic [39:0] opa [2];
  logic [39:0] opb [2];
  logic [39:0] alu_r [2];
  logic [63:0] mul_r [2];
  logic [1:0] az;
  logic [1:0] an;
  sdcd_cls_type cls;
  sdcd_len_type lenf;
  sdcd_aop_type aop;
  sdcd_fmt_type fmt;
  sdcd_cnd_type cnd;
  sdcd_bop_type bop;
  sdcd_xop_type xop;
  logic [7:0] tid;
  logic [31:0] imm;
  logic [4:0] dsti;

  // instruction from bus or from cache
  assign ins_v = r.fpend | r.cpend;
  assign ins = r.fpend ? prog_rdata_in[47:0] : r.cword;
  assign lenf = sdcd_len_type'(ins[F_LEN+:2]);
  assign cls = sdcd_cls_type'(ins[F_CLS+:2]);
  assign aop = sdcd_aop_type'(ins[F_AOP+:3]);
  assign fmt = sdcd_fmt_type'(ins[F_FMT+:2]);
  assign cnd = sdcd_cnd_type'(ins[F_CND+:2]);
  assign bop = sdcd_bop_type'(ins[F_SUB+:3]);
  assign xop = sdcd_xop_type'(ins[F_SUB+:3]);
  assign tid = ins[F_ID+:8];
  assign imm = ins[31:0];
  assign rb = r.mode[MB_SRF];
  assign dsti = {rb, ins[F_DST+:4]};
  assign ena = {r.mode[MB_SEN], 1'b1};

  // length in 16-bit parcels
  assign compact = (lenf == L32) || (lenf == L16);
  assign len16 = (lenf == L32) ? AW'(2) : (lenf == L16) ? AW'(1) : AW'(3);
  assign flt = ins_v && compact && (r.faddr >= ASYNC_BASE);
  assign exe = ins_v && !flt;
  assign pbusy = exe && ((cls == K_CMP && ins[F_PRD]) || (cls == K_XFR && (xop == X_PRD || xop == X_PWR)));
  assign nt = ins_v ? r.faddr + len16 : r.pc;
  assign ti = nt[CIW-1:0];
  assign fi = r.faddr[CIW-1:0];
  assign ags[0] = {r.mode[MB_SAG], ins[F_AG1+:3]};
  assign ags[1] = {r.mode[MB_SAG], ins[F_AG2+:3]};

  // one element and one generator per lane
  for (genvar g = 0; g < 2; g++) begin : g_lane
    sdcd_pe_if pif ();
    sdcd_pe u_pe (
      .pe_bus(pif)
    );
    assign pif.a = opa[g];
    assign pif.b = opb[g];
    assign pif.aop = aop;
    assign pif.fmt = fmt;
    assign alu_r[g] = pif.alu_r;
    assign mul_r[g] = pif.mul_r;
    assign az[g] = pif.az;
    assign an[g] = pif.an;
    assign opa[g] = (g == 0) ? r.xr[{rb, ins[F_SA+:4]}] : r.yr[{rb, ins[F_SA+:4]}];
    assign opb[g] = (g == 0) ? r.xr[{rb, ins[F_SB+:4]}] : r.yr[{rb, ins[F_SB+:4]}];
    assign ok[g] = (cnd == C_ALW) || (cnd == C_IFZ && r.az[g]) || (cnd == C_IFN && r.an[g]);
    sdcd_wrap #(.AW(AW)) u_wrap (
      .ptr_in(r.ai[g][ags[g]]),
      .mod_in(r.am[g][ags[g]]),
      .base_in(r.ab[g][ags[g]]),
      .len_in(r.al[g][ags[g]]),
      .next_out(agn[g])
    );
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.mode = mode_control_word_one_in;
    next_r.prd = 1'b0;
    next_r.pwr = 1'b0;
    next_r.drd = 1'b0;
    next_r.dwr = 1'b0;
    next_r.ldd = 1'b0;
    next_r.ldp = 1'b0;
    next_r.tirq = 1'b0;
    next_r.tflag = 1'b0;
    next_r.fpend = 1'b0;
    next_r.cpend = 1'b0;
    next_r.dbx = r.xr[dbg_sel_in];
    next_r.dby = r.yr[dbg_sel_in];
    // loads issued last cycle land first, so this cycle's alu wins
    if (r.ldd) begin
      if (r.ldd_x) begin
        next_r.bxr = data_rdata_in;
      end else begin
        next_r.xr[r.ldd_r] = {data_rdata_in[31:0], 8'h00};
        if (r.mode[MB_SEN]) begin
          next_r.yr[r.ldd_r] = {data_rdata_in[63:32], 8'h00};
        end
      end
    end
    if (r.ldp) begin
      if (r.ldp_x) begin
        next_r.bxr = prog_rdata_in;
      end else begin
        next_r.xr[r.ldp_r] = {prog_rdata_in[31:0], 8'h00};
        if (r.mode[MB_SEN]) begin
          next_r.yr[r.ldp_r] = {prog_rdata_in[63:32], 8'h00};
        end
      end
    end
    // core timer
    if (r.tctl[TC_EN]) begin
      if (r.tcnt == 32'h0000_0000) begin
        next_r.tcnt = r.tper;
        next_r.tirq = 1'b1;
        next_r.tflag = r.tctl[TC_FLG];
      end else begin
        next_r.tcnt = r.tcnt - 32'h0000_0001;
      end
    end
    // fill the cache with a fetch that was delayed by a collision
    if (r.fpend && r.miss) begin
      next_r.cv[fi] = 1'b1;
      next_r.ctag[fi] = r.faddr;
      next_r.cdat[fi] = ins;
      next_r.miss = 1'b0;
    end
    if (flt) begin
      next_r.fault = 1'b1;
    end
    // execute
    if (exe) begin
      unique case (cls)
        K_CMP: begin
          for (int g = 0; g < 2; g++) begin
            if (ena[g] && ok[g]) begin
              if (g == 0) begin
                next_r.xr[dsti] = alu_r[g];
              end else begin
                next_r.yr[dsti] = alu_r[g];
              end
              next_r.az[g] = az[g];
              next_r.an[g] = an[g];
              if (ins[F_MUL]) begin
                next_r.mr[r.mode[MB_SMR]][g] = mul_r[g];
              end
            end
          end
          if (ins[F_DRD]) begin
            next_r.drd = 1'b1;
            next_r.da = r.ai[0][ags[0]];
            next_r.ai[0][ags[0]] = agn[0];
            next_r.ldd = 1'b1;
            next_r.ldd_x = 1'b0;
            next_r.ldd_r = {rb, ins[F_DLR+:4]};
          end
          if (ins[F_PRD]) begin
            next_r.prd = 1'b1;
            next_r.pa = r.ai[1][ags[1]];
            next_r.ai[1][ags[1]] = agn[1];
            next_r.ldp = 1'b1;
            next_r.ldp_x = 1'b0;
            next_r.ldp_r = {rb, ins[F_PLR+:4]};
          end
        end
        K_LDI: begin
          if (tid < ID_AGLIM) begin
            unique case (tid[4:3])
              2'h0: next_r.ai[tid[5]][{r.mode[MB_SAG], tid[2:0]}] = AW'(imm);
              2'h1: next_r.am[tid[5]][{r.mode[MB_SAG], tid[2:0]}] = AW'(imm);
              2'h2: next_r.ab[tid[5]][{r.mode[MB_SAG], tid[2:0]}] = AW'(imm);
              2'h3: next_r.al[tid[5]][{r.mode[MB_SAG], tid[2:0]}] = AW'(imm);
            endcase
          end else if (tid[7:2] == ID_UBR[7:2]) begin
            next_r.ubr[tid[1:0]] = imm;
          end else if (tid == ID_TPER) begin
            next_r.tper = imm;
            next_r.tcnt = imm;
          end else if (tid == ID_TCTL) begin
            next_r.tctl = imm[1:0];
          end
        end
        K_BIT: begin
          unique case (bop)
            B_SET: next_r.ubr[ins[F_UIX+:2]] = r.ubr[ins[F_UIX+:2]] | imm;
            B_CLR: next_r.ubr[ins[F_UIX+:2]] = r.ubr[ins[F_UIX+:2]] & ~imm;
            B_TGL: next_r.ubr[ins[F_UIX+:2]] = r.ubr[ins[F_UIX+:2]] ^ imm;
            B_TST: next_r.utest = (r.ubr[ins[F_UIX+:2]] & imm) == imm;
            B_XOR: next_r.utest = (r.ubr[ins[F_UIX+:2]] ^ imm) == 32'h0000_0000;
            default: next_r.utest = r.utest;
          endcase
        end
        K_XFR: begin
          unique case (xop)
            X_DRD: begin
              next_r.drd = 1'b1;
              next_r.da = r.ai[0][ags[0]];
              next_r.ai[0][ags[0]] = agn[0];
              next_r.ldd = 1'b1;
              next_r.ldd_x = 1'b1;
            end
            X_PRD: begin
              next_r.prd = 1'b1;
              next_r.pa = r.ai[1][ags[1]];
              next_r.ai[1][ags[1]] = agn[1];
              next_r.ldp = 1'b1;
              next_r.ldp_x = 1'b1;
            end
            X_DWR: begin
              next_r.dwr = 1'b1;
              next_r.da = r.ai[0][ags[0]];
              next_r.ai[0][ags[0]] = agn[0];
              next_r.dwd = r.bxr;
            end
            X_PWR: begin
              next_r.pwr = 1'b1;
              next_r.pa = r.ai[1][ags[1]];
              next_r.ai[1][ags[1]] = agn[1];
              next_r.pwd = r.bxr;
            end
            X_FROM_REG: next_r.bxr = {24'h00_0000, r.xr[dsti]};
            X_TO_REG: next_r.xr[dsti] = r.bxr[39:0];
            default: next_r.bxr = r.bxr;
          endcase
        end
      endcase
    end
    // fetch: bus when free, else cache, else retry and fill
    if (!pbusy) begin
      next_r.prd = 1'b1;
      next_r.pa = nt;
      next_r.fpend = 1'b1;
      next_r.faddr = nt;
      next_r.pc = nt;
    end else if (r.cv[ti] && r.ctag[ti] == nt) begin
      next_r.cpend = 1'b1;
      next_r.cword = r.cdat[ti];
      next_r.faddr = nt;
      next_r.pc = nt;
    end else begin
      next_r.pc = nt;
      next_r.miss = 1'b1;
    end
  end

  // register the state, all zero after reset
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      r <= '0;
      r.mode <= RST_MODE;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prog_addr_out = r.pa;
  assign prog_rd_out = r.prd;
  assign prog_wr_out = r.pwr;
  assign prog_wdata_out = r.pwd;
  assign data_addr_out = r.da;
  assign data_rd_out = r.drd;
  assign data_wr_out = r.dwr;
  assign data_wdata_out = r.dwd;
  assign timer_irq_out = r.tirq;
  assign timer_expired_flag_pin_out = r.tflag;
  assign timer_expired_flag_pin_oe_out = r.tctl[TC_FLG];
  assign bit_test_out = r.utest;
  assign fetch_fault_out = r.fault;
  assign second_pe_active_out = r.mode[MB_SEN];
  assign dbg_x_out = r.dbx;
  assign dbg_y_out = r.dby;

endmodule : sdcd_core

// >>> rtl/sdcd_pe.sv
// processing element: single-cycle alu, shifter and multiplier
`timescale 1ns/1ps
module sdcd_pe import sdcd_pkg::*; (
  sdcd_pe_if.pe pe_bus // operands in, results out
);
  logic signed [31:0] xa;
  logic signed [31:0] xb;
  logic signed [63:0] fix_p;
  logic [63:0] man_p;
  logic [8:0] ex;
  logic [39:0] flt_r;
  logic [31:0] r32;

  // fixed-point view sits in the upper 32 bits
  assign xa = pe_bus.a[39:8];
  assign xb = pe_bus.b[39:8];

  // alu and shifter
  always_comb begin
    unique case (pe_bus.aop)
      A_ADD: r32 = xa + xb;
      A_SUB: r32 = xa - xb;
      A_AND: r32 = xa & xb;
      A_OR: r32 = xa | xb;
      A_XOR: r32 = xa ^ xb;
      A_PASS: r32 = xa;
      A_NEG: r32 = -xa;
      A_SHF: r32 = xb[5] ? (xa >>> xb[4:0]) : (xa << xb[4:0]);
    endcase
  end
  assign pe_bus.alu_r = {r32, 8'h00};
  assign pe_bus.az = (r32 == 32'h0000_0000);
  assign pe_bus.an = r32[31];

  // float multiply on the 40-bit layout, 32-bit float has zero low byte
  assign man_p = {32'h0000_0000, 1'b1, pe_bus.a[30:0]} * {32'h0000_0000, 1'b1, pe_bus.b[30:0]};
  assign ex = {1'b0, pe_bus.a[38:31]} + {1'b0, pe_bus.b[38:31]} - EXP_BIAS + {8'h00, man_p[63]};
  always_comb begin
    flt_r = {pe_bus.a[39] ^ pe_bus.b[39], ex[7:0], man_p[63] ? man_p[62:32] : man_p[61:31]};
    if (pe_bus.a[38:31] == 8'h00 || pe_bus.b[38:31] == 8'h00) begin
      flt_r = 40'h00_0000_0000; // zero operand flushes
    end
    if (pe_bus.fmt == D_F32) begin
      flt_r = flt_r & F32_MASK;
    end
  end
  assign fix_p = xa * xb;
  assign pe_bus.mul_r = (pe_bus.fmt == D_FIX) ? fix_p : {24'h00_0000, flt_r};

endmodule : sdcd_pe

// >>> rtl/sdcd_pe_if.sv
// interface: operands and results between the core and one processing element
`timescale 1ns/1ps
interface sdcd_pe_if;
  import sdcd_pkg::*;
  logic [39:0] a;
  logic [39:0] b;
  sdcd_aop_type aop;
  sdcd_fmt_type fmt;
  logic [39:0] alu_r;
  logic [63:0] mul_r;
  logic az;
  logic an;
  modport core (output a, b, aop, fmt, input alu_r, mul_r, az, an);
  modport pe (input a, b, aop, fmt, output alu_r, mul_r, az, an);
endinterface : sdcd_pe_if

// >>> rtl/sdcd_pkg.sv
// package: field layout, mode bits and encodings of the simd dsp core datapath
package sdcd_pkg;

  // ****************************************
  // instruction word field positions
  // ****************************************
  localparam int F_LEN = 46; // length code, 2 bits
  localparam int F_CLS = 44; // class, 2 bits
  localparam int F_DST = 40; // alu destination / transfer register
  localparam int F_SA = 36; // first operand register
  localparam int F_SB = 32; // second operand register
  localparam int F_AOP = 29; // alu operation, 3 bits
  localparam int F_MUL = 28; // multiplier also runs
  localparam int F_FMT = 26; // data format, 2 bits
  localparam int F_DRD = 25; // data bus load
  localparam int F_PRD = 24; // program bus load
  localparam int F_DLR = 20; // data bus load register
  localparam int F_PLR = 16; // program bus load register
  localparam int F_AG1 = 13; // generator 1 set, 3 bits
  localparam int F_AG2 = 10; // generator 2 set, 3 bits
  localparam int F_CND = 8; // condition, 2 bits
  localparam int F_ID = 32; // immediate target id, 8 bits
  localparam int F_UIX = 40; // bit register index, 2 bits
  localparam int F_SUB = 32; // bit or exchange sub-op, 3 bits

  // ****************************************
  // mode word bits, timer control, targets
  // ****************************************
  localparam int MB_SEN = 0; // second element enable
  localparam int MB_SRF = 1; // secondary data registers
  localparam int MB_SAG = 2; // secondary generator registers
  localparam int MB_SMR = 3; // secondary multiplier results
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam int TC_EN = 0;
  localparam int TC_FLG = 1;
  localparam logic [7:0] ID_AGLIM = 8'h40; // below: generator regs
  localparam logic [7:0] ID_UBR = 8'h40; // 8'h40..8'h43
  localparam logic [7:0] ID_TPER = 8'h44;
  localparam logic [7:0] ID_TCTL = 8'h45;
  localparam logic [39:0] F32_MASK = 40'hff_ffff_ff00;
  localparam logic [8:0] EXP_BIAS = 9'h07f;

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {L48, L32, L16} sdcd_len_type;
  typedef enum logic [1:0] {K_CMP, K_LDI, K_BIT, K_XFR} sdcd_cls_type;
  typedef enum logic [2:0] {A_ADD, A_SUB, A_AND, A_OR, A_XOR, A_PASS, A_NEG, A_SHF} sdcd_aop_type;
  typedef enum logic [1:0] {D_FIX, D_F32, D_F40} sdcd_fmt_type;
  typedef enum logic [1:0] {C_ALW, C_IFZ, C_IFN} sdcd_cnd_type;
  typedef enum logic [2:0] {B_SET, B_CLR, B_TGL, B_TST, B_XOR} sdcd_bop_type;
  typedef enum logic [2:0] {X_DRD, X_PRD, X_DWR, X_PWR, X_FROM_REG, X_TO_REG} sdcd_xop_type;

endpackage : sdcd_pkg

// >>> rtl/sdcd_wrap.sv
// address generator step: post-modify with circular wrap
`timescale 1ns/1ps
module sdcd_wrap #(
  parameter int AW = 32 // address width
) (
  input wire logic [AW-1:0] ptr_in, // current pointer
  input wire logic [AW-1:0] mod_in, // signed modifier
  input wire logic [AW-1:0] base_in, // buffer base
  input wire logic [AW-1:0] len_in, // buffer length, zero is linear
  output logic [AW-1:0] next_out // updated pointer
);
  logic [AW-1:0] sum;
  logic [AW-1:0] lim;

  assign sum = ptr_in + mod_in;
  assign lim = base_in + len_in;

  // wrap at either end of an arbitrary buffer
  always_comb begin
    next_out = sum;
    if (len_in != '0) begin
      if (!mod_in[AW-1] && sum >= lim) begin
        next_out = sum - len_in;
      end else if (mod_in[AW-1] && sum < base_in) begin
        next_out = sum + len_in;
      end
    end
  end

endmodule : sdcd_wrap

// >>> tb/sdcd_core_monitor.sv
// checker: port-level properties of the simd dsp core datapath
`timescale 1ns/1ps
module sdcd_core_monitor import sdcd_pkg::*; #(
  parameter int AW = 32, // address width
  parameter int CN = 8, // cache entries
  parameter logic [AW-1:0] ASYNC_BASE = {1'b1, {(AW-1){1'b0}}} // async start
) (
  input wire logic mclk_in, // core clock
  input wire logic resetn_in, // sync reset
  input wire logic [3:0] mode_control_word_one_in, // mode bits
  input wire logic [4:0] dbg_sel_in, // observed index
  input wire logic [AW-1:0] prog_addr_out, // program address
  input wire logic prog_rd_out, // program read
  input wire logic data_rd_out, // data read
  input wire logic timer_irq_out, // timer pulse
  input wire logic timer_expired_flag_pin_out, // flag pin
  input wire logic timer_expired_flag_pin_oe_out, // flag pin driven
  input wire logic fetch_fault_out, // refused fetch
  input wire logic second_pe_active_out, // second element on
  input wire logic [39:0] dbg_y_out // second element view
);
  logic seen_async;
  logic y_seen;
  // ****************************************
  // history of async fetches and element use
  // ****************************************
  always_ff @(posedge mclk_in) begin
    seen_async <= resetn_in & (seen_async | (prog_rd_out & (prog_addr_out >= ASYNC_BASE)));
    y_seen <= resetn_in & (y_seen | second_pe_active_out);
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  sequence release_s;
    $rose(resetn_in);
  endsequence
  sequence y_idle_s;
    !second_pe_active_out && $stable(dbg_sel_in);
  endsequence
  chk_first_fetch: assert property (release_s |=> prog_rd_out && !data_rd_out && prog_addr_out == '0)
    else $error("first fetch after reset missing");
  chk_reset_quiet: assert property (release_s |->
    !timer_irq_out && !fetch_fault_out && !second_pe_active_out)
    else $error("state not cleared by reset");
  chk_pe_follow: assert property ($past(resetn_in) |-> second_pe_active_out == $past(mode_control_word_one_in[0]))
    else $error("second element state wrong");
  chk_flag_irq: assert property (timer_expired_flag_pin_out |-> timer_irq_out && timer_expired_flag_pin_oe_out)
    else $error("flag pin without expiry");
  chk_fault_sticky: assert property (fetch_fault_out |=> fetch_fault_out)
    else $error("fault flag dropped");
  chk_fault_cause: assert property (fetch_fault_out |-> seen_async)
    else $error("fault without async fetch");
  chk_pe_quiet: assert property (y_idle_s [*4] |=> $stable(dbg_y_out))
    else $error("idle second element changed");
  chk_y_silent: assert property (!y_seen |-> dbg_y_out == '0)
    else $error("unused second element written");
endmodule : sdcd_core_monitor

// >>> tb/sdcd_mem.sv
// model: program and data memories answering within the read cycle
`timescale 1ns/1ps
module sdcd_mem #(
  parameter logic [63:0] FILL = 64'h0 // word of unwritten program places
) (
  input wire logic clk_in, // core clock
  input wire logic [31:0] prog_addr_in, // program address
  input wire logic prog_rd_in, // program read
  input wire logic prog_wr_in, // program write
  input wire logic [63:0] prog_wdata_in, // program write data
  input wire logic [31:0] data_addr_in, // data address
  input wire logic data_rd_in, // data read
  input wire logic data_wr_in, // data write
  input wire logic [63:0] data_wdata_in, // data write data
  output logic [63:0] prog_rdata_out, // program read data
  output logic [63:0] data_rdata_out // data read data
);
  logic [63:0] pm [int];
  logic [63:0] dm [int];
  logic [63:0] plast = 64'h0;
  logic [63:0] dlast = 64'h0;
  // same-cycle answer, as the core samples it; idle lines show the inverse
  always @(prog_rd_in, prog_addr_in, plast, data_rd_in, data_addr_in, dlast) begin
    prog_rdata_out = !prog_rd_in ? ~plast : pm.exists(int'(prog_addr_in)) ? pm[int'(prog_addr_in)] : FILL;
    data_rdata_out = !data_rd_in ? ~dlast : dm.exists(int'(data_addr_in)) ? dm[int'(data_addr_in)] : 64'h0;
  end
  always @(posedge clk_in) begin
    plast <= prog_rdata_out;
    dlast <= data_rdata_out;
    if (prog_wr_in) pm[int'(prog_addr_in)] = prog_wdata_in;
    if (data_wr_in) dm[int'(data_addr_in)] = data_wdata_in;
  end
endmodule : sdcd_mem

// >>> tb/simd_dsp_core_datapath_bench.sv
// bench: program-driven checks of the simd dsp core datapath
`timescale 1ns/1ps
module simd_dsp_core_datapath_bench;
  import sdcd_pkg::*;
  typedef struct packed {logic [3:0] m; logic [4:0] s; logic [39:0] x; logic [39:0] y;} sdcd_row_type;
  localparam logic [31:0] ABASE = 32'h0000_0040;
  localparam logic [47:0] NOP = 48'h3007_0000_0000;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] mode = 4'h0;
  logic [4:0] sel = 5'h00;
  logic [63:0] prd, drd, pwd, dwd;
  logic [31:0] pa, da;
  logic prr, pww, drr, dww, irq, flg, oe, btst, flt, act;
  logic [39:0] dx, dy;
  int err_count = 0;
  int check_count = 0;
  int pc, n, fl;
  sdcd_row_type rows [9] = '{'{4'h1, 5'h01, 40'h300, 40'h500}, '{4'h1, 5'h02, 40'h400, 40'h700},
    '{4'h1, 5'h03, 40'h700, 40'hc00}, '{4'h1, 5'h04, 40'h300, 40'h500}, '{4'h3, 5'h13, 40'h700, 40'hc00},
    '{4'h3, 5'h03, 40'h0, 40'h0}, '{4'h0, 5'h03, 40'h700, 40'h0}, '{4'h0, 5'h04, 40'h300, 40'h0},
    '{4'h0, 5'h13, 40'h0, 40'h0}};
  sdcd_core #(.ASYNC_BASE(ABASE)) sdcd_core_inst (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .mode_control_word_one_in(mode), .dbg_sel_in(sel), .prog_rdata_in(prd), .data_rdata_in(drd),
    .prog_addr_out(pa), .prog_rd_out(prr), .prog_wr_out(pww), .prog_wdata_out(pwd), .data_addr_out(da),
    .data_rd_out(drr), .data_wr_out(dww), .data_wdata_out(dwd), .timer_irq_out(irq),
    .timer_expired_flag_pin_out(flg), .timer_expired_flag_pin_oe_out(oe), .bit_test_out(btst),
    .fetch_fault_out(flt), .second_pe_active_out(act), .dbg_x_out(dx), .dbg_y_out(dy));
  sdcd_mem #(.FILL({16'h0, NOP})) sdcd_mem_inst (.clk_in(mclk_in), .prog_addr_in(pa), .prog_rd_in(prr),
    .prog_wr_in(pww), .prog_wdata_in(pwd), .data_addr_in(da), .data_rd_in(drr), .data_wr_in(dww),
    .data_wdata_in(dwd), .prog_rdata_out(prd), .data_rdata_out(drd));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    check_count++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic conclude;
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // place a word and step by its length in parcels
  task automatic put(input logic [47:0] w);
    sdcd_mem_inst.pm[pc] = {16'h0, w};
    pc += (w[47:46] == 2'h2) ? 1 : (w[47:46] == 2'h1) ? 2 : 3;
  endtask : put
  task automatic run(input logic [3:0] m);
    @(posedge mclk_in);
    mode <= m;
    resetn_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (150) @(posedge mclk_in);
  endtask : run
  initial forever #12.5 mclk_in = ~mclk_in;
  // watchdog cuts a hang short
  initial begin
    repeat (3000) @(posedge mclk_in);
    err_count++;
    conclude();
  end
  initial begin
    sdcd_mem_inst.dm[256] = 64'h0000_0005_0000_0003;
    sdcd_mem_inst.dm[257] = 64'h0000_0007_0000_0004;
    pc = 0;
    put(48'h1010_0000_0100); // buffer base
    put(48'h1018_0000_0002); // buffer length two
    put(48'h1008_0000_0001); // step one
    put(48'h1000_0000_0100); // pointer
    put(48'h1044_0000_0003); // timer period
    put(48'h1045_0000_0003); // timer on, drives flag pin
    put(48'h2000_0000_00f0); // set
    put(48'h2001_0000_0010); // clear
    put(48'h2002_0000_0001); // toggle
    put(48'h2003_0000_00c1); // test
    put(48'h2004_0000_00e1); // xor compare
    put(48'h7007_0000_0000); // short form, internal region
    put(48'h0000_a210_0000); // load first value
    put(48'h0000_a220_0000); // load second value
    put(48'h0000_a240_0000); // load after pointer wrap
    repeat (3) put(NOP);
    put(48'h0312_0000_0000); // add both loads
    while (pc < int'(ABASE)) put(NOP);
    put(48'hb007_0000_0000); // short form, async region
    // table rows: one program run per mode, then register views
    foreach (rows[i]) begin
      if (i == 0 || rows[i].m != rows[i-1].m) run(rows[i].m);
      @(posedge mclk_in);
      sel <= rows[i].s;
      repeat (2) @(posedge mclk_in);
      #1;
      check(dx, rows[i].x);
      check(dy, rows[i].y);
      check(act, rows[i].m[0]);
    end
    check(flt, 1'b1);
    check(btst, 1'b1);
    n = 0;
    fl = 0;
    repeat (40) begin
      @(posedge mclk_in);
      #1;
      n += (irq === 1'b1);
      fl += (flg === 1'b1);
    end
    check(n, 10);
    check(fl, 10);
    check(oe, 1'b1);
    conclude();
  end
endmodule : simd_dsp_core_datapath_bench
bind sdcd_core sdcd_core_monitor #(.AW(AW), .CN(CN), .ASYNC_BASE(ASYNC_BASE)) sdcd_core_monitor_inst (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .mode_control_word_one_in(mode_control_word_one_in),
  .dbg_sel_in(dbg_sel_in), .prog_addr_out(prog_addr_out), .prog_rd_out(prog_rd_out), .data_rd_out(data_rd_out),
  .timer_irq_out(timer_irq_out), .timer_expired_flag_pin_out(timer_expired_flag_pin_out),
  .timer_expired_flag_pin_oe_out(timer_expired_flag_pin_oe_out), .fetch_fault_out(fetch_fault_out),
  .second_pe_active_out(second_pe_active_out), .dbg_y_out(dbg_y_out));
